//--- inc/mode_select_pkg.sv
package mode_select_pkg;

	// system clock and sync-input frequency window
	localparam int unsigned CLK_FREQ_KHZ = 250000;
	localparam int unsigned SYNC_FREQ_MIN_KHZ = 200;
	localparam int unsigned SYNC_FREQ_MAX_KHZ = 2200;
	// shortest legal sync period rounds up, longest rounds down
	localparam int unsigned SYNC_PERIOD_MIN_CYC = (CLK_FREQ_KHZ + SYNC_FREQ_MAX_KHZ - 1) / SYNC_FREQ_MAX_KHZ;
	localparam int unsigned SYNC_PERIOD_MAX_CYC = CLK_FREQ_KHZ / SYNC_FREQ_MIN_KHZ;
	// mode settle time in clock cycles
	localparam int unsigned MODE_SETTLE_CYC = 1024;

	// pulse counts of the mode-select train
	localparam logic [11:0] TRAIN_DOUBLE = 12'h002;
	localparam logic [11:0] TRAIN_LATCH = 12'h004;
	localparam logic [11:0] TRAIN_SYNC = 12'h800;

	// factory default switching frequencies
	localparam logic [11:0] FREQ_HIGH_KHZ = 12'h834;
	localparam logic [11:0] FREQ_LOW_KHZ = 12'h190;

	// register map
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] TRAIN_OFFSET = 8'h08;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int unsigned CTRL_RESTART_BIT = 0;
	localparam int unsigned CTRL_INHIBIT_BIT = 1;
	localparam int unsigned STAT_MODE_LSB = 0;
	localparam int unsigned STAT_SS_BIT = 2;
	localparam int unsigned STAT_LATCHED_BIT = 3;
	localparam int unsigned STAT_PWR_LSB = 4;
	localparam int unsigned STAT_FOLLOW_BIT = 6;
	localparam int unsigned STAT_REDUCE_BIT = 7;
	localparam int unsigned STAT_STRAP_BIT = 8;

	typedef enum logic [1:0] {
		OP_AUTO = 2'b00,
		OP_FORCED_PWM = 2'b01,
		OP_SYNC = 2'b11
	} op_mode_type;

	typedef enum logic [1:0] {
		PWR_SHUTDOWN = 2'b00,
		PWR_STANDBY = 2'b01,
		PWR_SWITCHING = 2'b11
	} power_state_type;

	typedef enum logic [1:0] {
		LVL_AUTO_SS = 2'b00,
		LVL_FORCED_PWM_SS = 2'b01,
		LVL_FORCED_PWM_NOSS = 2'b11,
		LVL_AUTO_NOSS = 2'b10
	} level_code_type;

	typedef struct packed {
		logic select_above_low;
		logic select_above_high;
		logic select_mid_upper_level;
		logic select_top_level;
		logic strap_auto_no_ss;
		logic en_above_wake;
		logic en_above_enable;
		logic vin_above_min;
		logic foldback_active;
		logic min_on_limited;
		logic min_off_limited;
	} analog_in_type;

	typedef struct packed {
		op_mode_type mode;
		logic spread_spectrum_en;
		logic diode_emulation_en;
		logic pulse_ctrl_latched;
		power_state_type power_state;
		logic follow_ext_clock;
		logic freq_reduce;
		logic [11:0] default_freq_khz;
	} regulator_ctrl_type;

endpackage

//--- src/sync2.sv
`timescale 1ns/10ps
module sync2 #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] q_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule

//--- src/buck_mode_select_decoder.sv
`timescale 1ns/10ps
// Notes on behaviour
// - three modes: auto with pulse skipping, forced pwm, external sync
// - sync mode acts like forced pwm, diode emulation off
// - follow external clock only while min on/off time do not limit
// - lower frequency automatically when min on/off time limits ratio
// - factory default 2.1 MHz or 400 kHz; sync window 200 kHz to 2.2 MHz
// - enable below wake: shutdown; between: standby; above with vin and inhibit clear: switching
// - level scheme never enters sync mode
// - level: ground auto+ss, mid forced pwm+ss, high forced pwm no ss
// - level setting adopted only after held for settle time
// - spread spectrum off during frequency foldback, back on after
// - strap auto without ss is fixed until restart in level scheme only; pulse scheme settle still sets mode and ss
// - latch pulse scheme when fourth valid sync pulse completes
// - pulse scheme left only through restart
// - pulse: high forced pwm+ss, low auto+ss, clock sync no ss
// - pulse: auto/forced pwm change only after settle time
// - double pulse then steady level selects mode with ss off
// - sync mode entered only after 2048 valid sync pulses
// - steady pin beyond settle leaves sync, ss back on, pulse scheme kept
module buck_mode_select_decoder import mode_select_pkg::*; #(
	parameter int unsigned MODE_SETTLE_CYCLES = MODE_SETTLE_CYC,
	parameter int unsigned PERIOD_MIN_CYCLES = SYNC_PERIOD_MIN_CYC,
	parameter int unsigned PERIOD_MAX_CYCLES = SYNC_PERIOD_MAX_CYC,
	parameter bit FACTORY_LOW_FREQ = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire analog_in_type analog_in,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output regulator_ctrl_type reg_ctrl
);
	localparam logic [15:0] SETTLE_W = 16'(MODE_SETTLE_CYCLES);
	localparam logic [15:0] PMIN_W = 16'(PERIOD_MIN_CYCLES);
	localparam logic [15:0] PMAX_W = 16'(PERIOD_MAX_CYCLES);

	analog_in_type ain;
	logic pin_hi, rise, fall, edge_any, settle, restart;

	logic pin_prev_r, pin_prev_nxt;
	logic [15:0] period_r, period_nxt;
	logic [15:0] stable_r, stable_nxt;
	logic armed_r, armed_nxt;
	logic [11:0] train_r, train_nxt;
	logic latched_r, latched_nxt;

	level_code_type lvl_code, cand_r, cand_nxt;
	logic [15:0] hold_r, hold_nxt;
	logic strap_lock_r, strap_lock_nxt;
	op_mode_type mode_sel_r, mode_sel_nxt;
	logic ss_sel_r, ss_sel_nxt;

	regulator_ctrl_type out_r, out_nxt;

	logic [1:0] ctrl_r, ctrl_nxt;
	logic restart_req_r, restart_req_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [31:0] status_w;

	// pin comparators cross into the clock domain
	sync2 #(.WIDTH($bits(analog_in_type))) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(analog_in),
		.q(ain)
	);

	assign pin_hi = ain.select_above_high;
	assign rise = pin_hi & ~pin_prev_r;
	assign fall = ~pin_hi & pin_prev_r;
	assign edge_any = rise | fall;
	assign settle = (stable_r == SETTLE_W) & ~edge_any;
	// restart only by shutdown or software
	assign restart = restart_req_r | (out_r.power_state == PWR_SHUTDOWN);

	// pulse train measurement
	always_comb begin
		pin_prev_nxt = pin_hi;
		period_nxt = (period_r == 16'hFFFF) ? period_r : period_r + 16'h0001;
		stable_nxt = (stable_r == 16'hFFFF) ? stable_r : stable_r + 16'h0001;
		armed_nxt = armed_r;
		train_nxt = train_r;
		latched_nxt = latched_r;
		if (rise) begin
			period_nxt = '0;
			armed_nxt = 1'b1;
			if (armed_r && period_r >= PMIN_W && period_r <= PMAX_W) begin
				train_nxt = (train_r == TRAIN_SYNC) ? train_r : train_r + 12'h001;
			end else begin
				train_nxt = 12'h001;
			end
		end else if (period_r == PMAX_W) begin
			armed_nxt = 1'b0;
		end
		if (edge_any) begin
			stable_nxt = '0;
		end
		if (fall && train_r >= TRAIN_LATCH) begin
			latched_nxt = 1'b1;
		end
		if (settle) begin
			train_nxt = '0;
		end
		if (restart) begin
			latched_nxt = 1'b0;
			train_nxt = '0;
			armed_nxt = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_r <= 1'b0;
			period_r <= '0;
			stable_r <= '0;
			armed_r <= 1'b0;
			train_r <= '0;
			latched_r <= 1'b0;
		end else begin
			pin_prev_r <= pin_prev_nxt;
			period_r <= period_nxt;
			stable_r <= stable_nxt;
			armed_r <= armed_nxt;
			train_r <= train_nxt;
			latched_r <= latched_nxt;
		end
	end

	always_comb begin
		lvl_code = cand_r;
		if (ain.select_top_level) begin
			lvl_code = LVL_FORCED_PWM_NOSS;
		end else if (ain.select_above_high && !ain.select_mid_upper_level) begin
			lvl_code = LVL_FORCED_PWM_SS;
		end else if (!ain.select_above_low) begin
			lvl_code = ain.strap_auto_no_ss ? LVL_AUTO_NOSS : LVL_AUTO_SS;
		end
	end

	// mode selection for both schemes
	always_comb begin
		cand_nxt = cand_r;
		hold_nxt = (hold_r == 16'hFFFF) ? hold_r : hold_r + 16'h0001;
		strap_lock_nxt = strap_lock_r;
		mode_sel_nxt = mode_sel_r;
		ss_sel_nxt = ss_sel_r;
		if (lvl_code != cand_r) begin
			cand_nxt = lvl_code;
			hold_nxt = '0;
		end
		if (!latched_r) begin
			if (hold_r == SETTLE_W && lvl_code == cand_r && !strap_lock_r) begin
				// level scheme picks auto or forced pwm only
				mode_sel_nxt = (cand_r == LVL_FORCED_PWM_SS || cand_r == LVL_FORCED_PWM_NOSS) ? OP_FORCED_PWM : OP_AUTO;
				ss_sel_nxt = (cand_r == LVL_AUTO_SS || cand_r == LVL_FORCED_PWM_SS);
				strap_lock_nxt = (cand_r == LVL_AUTO_NOSS);
			end
		end else if (train_nxt == TRAIN_SYNC && train_r != TRAIN_SYNC) begin
			mode_sel_nxt = OP_SYNC;
			ss_sel_nxt = 1'b0;
		end else if (settle) begin
			mode_sel_nxt = pin_hi ? OP_FORCED_PWM : OP_AUTO;
			ss_sel_nxt = (train_r != TRAIN_DOUBLE);
		end
		if (restart) begin
			strap_lock_nxt = 1'b0;
			mode_sel_nxt = OP_AUTO;
			ss_sel_nxt = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cand_r <= LVL_AUTO_SS;
			hold_r <= '0;
			strap_lock_r <= 1'b0;
			mode_sel_r <= OP_AUTO;
			ss_sel_r <= 1'b1;
		end else begin
			cand_r <= cand_nxt;
			hold_r <= hold_nxt;
			strap_lock_r <= strap_lock_nxt;
			mode_sel_r <= mode_sel_nxt;
			ss_sel_r <= ss_sel_nxt;
		end
	end

	// outputs toward the power stage
	always_comb begin
		out_nxt.mode = mode_sel_r;
		out_nxt.spread_spectrum_en = ss_sel_r & ~ain.foldback_active;
		out_nxt.diode_emulation_en = (mode_sel_r == OP_AUTO);
		out_nxt.pulse_ctrl_latched = latched_r;
		if (!ain.en_above_wake) begin
			out_nxt.power_state = PWR_SHUTDOWN;
		end else if (ain.en_above_enable && ain.vin_above_min && !ctrl_r[CTRL_INHIBIT_BIT]) begin
			out_nxt.power_state = PWR_SWITCHING;
		end else begin
			out_nxt.power_state = PWR_STANDBY;
		end
		out_nxt.follow_ext_clock = (mode_sel_r == OP_SYNC) & ~ain.min_on_limited & ~ain.min_off_limited;
		out_nxt.freq_reduce = ain.min_on_limited | ain.min_off_limited;
		out_nxt.default_freq_khz = FACTORY_LOW_FREQ ? FREQ_LOW_KHZ : FREQ_HIGH_KHZ;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_r <= '{mode: OP_AUTO, spread_spectrum_en: 1'b0, diode_emulation_en: 1'b1,
				pulse_ctrl_latched: 1'b0, power_state: PWR_SHUTDOWN, follow_ext_clock: 1'b0,
				freq_reduce: 1'b0, default_freq_khz: 12'h000};
		end else begin
			out_r <= out_nxt;
		end
	end

	// apb slave, one wait state
	always_comb begin
		status_w = '0;
		status_w[STAT_MODE_LSB +: 2] = out_r.mode;
		status_w[STAT_SS_BIT] = out_r.spread_spectrum_en;
		status_w[STAT_LATCHED_BIT] = out_r.pulse_ctrl_latched;
		status_w[STAT_PWR_LSB +: 2] = out_r.power_state;
		status_w[STAT_FOLLOW_BIT] = out_r.follow_ext_clock;
		status_w[STAT_REDUCE_BIT] = out_r.freq_reduce;
		status_w[STAT_STRAP_BIT] = strap_lock_r;
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		restart_req_nxt = 1'b0;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		if (psel && penable && !pready_r) begin
			pready_nxt = 1'b1;
			prdata_nxt = '0;
			unique case (paddr)
				CTRL_OFFSET: prdata_nxt[1:0] = ctrl_r;
				STATUS_OFFSET: prdata_nxt = status_w;
				TRAIN_OFFSET: prdata_nxt[11:0] = train_r;
				default: pslverr_nxt = 1'b1;
			endcase
		end
		if (psel && penable && pready_r && pwrite && paddr == CTRL_OFFSET) begin
			ctrl_nxt = pwdata[1:0] & 2'h2;
			restart_req_nxt = pwdata[CTRL_RESTART_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RESET;
			restart_req_r <= 1'b0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			restart_req_r <= restart_req_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign reg_ctrl = out_r;

	property p_sync_no_diode;
		@(posedge pclk) disable iff (!presetn) reg_ctrl.mode == OP_SYNC |-> !reg_ctrl.diode_emulation_en;
	endproperty
	a_sync_no_diode: assert property (p_sync_no_diode) else $error("diode emulation on in sync");

	property p_level_no_sync;
		@(posedge pclk) disable iff (!presetn) !latched_r |-> mode_sel_r != OP_SYNC;
	endproperty
	a_level_no_sync: assert property (p_level_no_sync) else $error("sync under level scheme");

	property p_latch_kept;
		@(posedge pclk) disable iff (!presetn) latched_r && !restart |=> latched_r;
	endproperty
	a_latch_kept: assert property (p_latch_kept) else $error("pulse scheme dropped");

	property p_latch_set;
		@(posedge pclk) disable iff (!presetn) fall && train_r >= TRAIN_LATCH && !restart |=> latched_r ##1 reg_ctrl.pulse_ctrl_latched;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("fourth pulse not latched");

	property p_fold_ss;
		@(posedge pclk) disable iff (!presetn) ain.foldback_active |=> !reg_ctrl.spread_spectrum_en;
	endproperty
	a_fold_ss: assert property (p_fold_ss) else $error("ss on in foldback");

	property p_follow;
		@(posedge pclk) disable iff (!presetn)
			reg_ctrl.follow_ext_clock |-> reg_ctrl.mode == OP_SYNC && !reg_ctrl.freq_reduce;
	endproperty
	a_follow: assert property (p_follow) else $error("follows clock while limited");

	property p_reduce;
		@(posedge pclk) disable iff (!presetn) ain.min_on_limited || ain.min_off_limited |=> reg_ctrl.freq_reduce;
	endproperty
	a_reduce: assert property (p_reduce) else $error("no frequency reduction");

	property p_shutdown;
		@(posedge pclk) disable iff (!presetn) !ain.en_above_wake |=> reg_ctrl.power_state == PWR_SHUTDOWN;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("not in shutdown");

	property p_sync_entry;
		@(posedge pclk) disable iff (!presetn)
			mode_sel_r == OP_SYNC && $past(mode_sel_r) != OP_SYNC |-> train_r == TRAIN_SYNC && !ss_sel_r;
	endproperty
	a_sync_entry: assert property (p_sync_entry) else $error("sync entered early");

	property p_level_settle;
		@(posedge pclk) disable iff (!presetn)
			!latched_r && !$past(latched_r) && !$past(restart) && $changed(mode_sel_r) |-> $past(hold_r) == SETTLE_W;
	endproperty
	a_level_settle: assert property (p_level_settle) else $error("level adopted before settle");

	c_latched: cover property (@(posedge pclk) disable iff (!presetn) $rose(latched_r));
	c_sync: cover property (@(posedge pclk) disable iff (!presetn) $rose(reg_ctrl.mode == OP_SYNC));
	c_double: cover property (@(posedge pclk) disable iff (!presetn) latched_r && settle && train_r == TRAIN_DOUBLE);
	c_switching: cover property (@(posedge pclk) disable iff (!presetn) reg_ctrl.power_state == PWR_SWITCHING);
endmodule

//--- tb/mode_pin_host.sv
`timescale 1ns/10ps
module mode_pin_host (
	output logic pin,
	input wire logic pclk
);
	// half period of the link clock: 32 ns at 4 ns per cycle
	localparam int unsigned HALF_CYC = 8;

	initial pin = 1'b0;

	task automatic half(input bit v);
		@(posedge pclk);
		pin <= v;
		repeat (HALF_CYC - 1) @(posedge pclk);
	endtask

	task automatic send(input int n, input bit end_high);
		int i;
		if (pin) begin
			half(1'b0);
		end
		for (i = 0; i < n; i++) begin
			half(1'b1);
			if (!(end_high && i == n - 1)) begin
				half(1'b0);
			end
		end
	endtask

	task automatic set_level(input bit v);
		@(posedge pclk);
		pin <= v;
	endtask
endmodule

//--- tb/buck_mode_select_decoder_test.sv
`timescale 1ns/10ps
module buck_mode_select_decoder_test import mode_select_pkg::*; ;
	localparam int unsigned SETTLE = 100;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err;
	regulator_ctrl_type reg_ctrl;
	analog_in_type ain;
	logic pin, mid_up, top, strap, wake, en, vin, fold, mon, moff;
	int n_mismatch, n_tests;
	assign ain = {pin, pin, mid_up, top, strap, wake, en, vin, fold, mon, moff};

	mode_pin_host host (.pin(pin), .pclk(pclk));
	buck_mode_select_decoder #(.MODE_SETTLE_CYCLES(SETTLE), .PERIOD_MIN_CYCLES(8), .PERIOD_MAX_CYCLES(40))
		dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .analog_in(ain), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .reg_ctrl(reg_ctrl));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task finish_test;
		if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			finish_test;
		end
	endtask

	task chk_mode(input op_mode_type m, input logic ss, input logic lat);
		check("mode", reg_ctrl.mode, m);
		check("spread", reg_ctrl.spread_spectrum_en, ss);
		check("diode", reg_ctrl.diode_emulation_en, m == OP_AUTO);
		check("latched", reg_ctrl.pulse_ctrl_latched, lat);
	endtask

	task t_power;
		apb(1'b0, 8'h0C, 32'h0000_0000);
		check("unmapped err", err, 1'b1);
		check("power off", reg_ctrl.power_state, PWR_SHUTDOWN);
		wake <= 1'b1;
		cyc(6);
		check("power wake", reg_ctrl.power_state, PWR_STANDBY);
		en <= 1'b1;
		cyc(6);
		check("power no vin", reg_ctrl.power_state, PWR_STANDBY);
		vin <= 1'b1;
		cyc(6);
		check("power on", reg_ctrl.power_state, PWR_SWITCHING);
		check("freq", reg_ctrl.default_freq_khz, FREQ_HIGH_KHZ);
		apb(1'b1, CTRL_OFFSET, 32'h0000_0002);
		cyc(3);
		check("power inhibit", reg_ctrl.power_state, PWR_STANDBY);
		apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
		cyc(SETTLE + 10);
	endtask

	task t_level;
		op_mode_type em [3];
		logic es [3];
		logic ep [3];
		logic emu [3];
		int i;
		em = '{OP_FORCED_PWM, OP_FORCED_PWM, OP_AUTO};
		es = '{1'b1, 1'b0, 1'b1};
		ep = '{1'b1, 1'b1, 1'b0};
		emu = '{1'b0, 1'b1, 1'b0};
		chk_mode(OP_AUTO, 1'b1, 1'b0);
		for (i = 0; i < 3; i++) begin
			host.set_level(ep[i]);
			mid_up <= emu[i];
			top <= emu[i];
			cyc(SETTLE / 2);
			chk_mode(i == 0 ? OP_AUTO : em[i - 1], i == 0 ? 1'b1 : es[i - 1], 1'b0);
			cyc(SETTLE);
			chk_mode(em[i], es[i], 1'b0);
		end
		fold <= 1'b1;
		cyc(6);
		check("fold ss", reg_ctrl.spread_spectrum_en, 1'b0);
		fold <= 1'b0;
		cyc(6);
		check("unfold ss", reg_ctrl.spread_spectrum_en, 1'b1);
	endtask

	task t_strap;
		strap <= 1'b1;
		cyc(SETTLE + 10);
		chk_mode(OP_AUTO, 1'b0, 1'b0);
		apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
		check("strap lock", rd[STAT_STRAP_BIT], 1'b1);
		host.set_level(1'b1);
		top <= 1'b1;
		mid_up <= 1'b1;
		cyc(SETTLE + 10);
		chk_mode(OP_AUTO, 1'b0, 1'b0);
		strap <= 1'b0;
		host.set_level(1'b0);
		top <= 1'b0;
		mid_up <= 1'b0;
		apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
		cyc(SETTLE + 10);
		chk_mode(OP_AUTO, 1'b1, 1'b0);
	endtask

	task t_pulse;
		host.send(3, 1'b0);
		cyc(10);
		chk_mode(OP_AUTO, 1'b1, 1'b0);
		cyc(SETTLE + 50);
		host.send(4, 1'b0);
		cyc(10);
		check("latch", reg_ctrl.pulse_ctrl_latched, 1'b1);
		cyc(SETTLE + 20);
		chk_mode(OP_AUTO, 1'b1, 1'b1);
		host.set_level(1'b1);
		cyc(SETTLE / 2);
		chk_mode(OP_AUTO, 1'b1, 1'b1);
		cyc(SETTLE);
		chk_mode(OP_FORCED_PWM, 1'b1, 1'b1);
		host.send(2, 1'b1);
		cyc(SETTLE + 20);
		chk_mode(OP_FORCED_PWM, 1'b0, 1'b1);
		host.send(2, 1'b0);
		apb(1'b0, TRAIN_OFFSET, 32'h0000_0000);
		check("train", rd, {20'h0_0000, TRAIN_DOUBLE});
		cyc(SETTLE + 20);
		chk_mode(OP_AUTO, 1'b0, 1'b1);
	endtask

	task t_sync;
		host.send(2040, 1'b0);
		check("early sync", reg_ctrl.mode == OP_SYNC, 1'b0);
		host.send(20, 1'b0);
		chk_mode(OP_SYNC, 1'b0, 1'b1);
		check("follow", reg_ctrl.follow_ext_clock, 1'b1);
		mon <= 1'b1;
		host.send(20, 1'b0);
		check("follow lim", reg_ctrl.follow_ext_clock, 1'b0);
		check("reduce", reg_ctrl.freq_reduce, 1'b1);
		mon <= 1'b0;
		moff <= 1'b1;
		cyc(6);
		check("follow off lim", reg_ctrl.follow_ext_clock, 1'b0);
		check("reduce off lim", reg_ctrl.freq_reduce, 1'b1);
		moff <= 1'b0;
		cyc(6);
		check("follow back", reg_ctrl.follow_ext_clock, 1'b1);
		check("reduce clear", reg_ctrl.freq_reduce, 1'b0);
		cyc(SETTLE + 50);
		chk_mode(OP_AUTO, 1'b1, 1'b1);
		apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
		cyc(5);
		check("restart", reg_ctrl.pulse_ctrl_latched, 1'b0);
		apb(1'b0, CTRL_OFFSET, 32'h0000_0000);
		check("ctrl read", rd, 32'h0000_0000);
	endtask

	initial begin
		n_mismatch = 0;
		n_tests = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{mid_up, top, strap, wake, en, vin, fold, mon, moff} = 9'h000;
		cyc(5);
		presetn <= 1'b1;
		cyc(2);
		t_power;
		t_level;
		t_strap;
		t_pulse;
		t_sync;
		finish_test;
	end
endmodule
